//--- hdl/adc_ctrl.sv
// Converter end: start, restart and completion control
// Notes on behaviour
// - Select and write pulse restarts running conversion
// - Aborted conversion leaves result latch unchanged
// - Done stays high through restart
// - Free running needs one power-up low pulse
// - Converter clock from CPU or RC
// - Host stretches cycles at high clock rates
// - Host stores sixteen successive results
// - Span split into 256 steps, 8-bit code
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_ctrl #(
  parameter int RES_BITS = `ADC_RES_BITS,
  parameter int CLK_DIV = `ADC_CLK_DIV
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic conv_clk_en, // Conversion clock strobe, one step per CLK_DIV strobes
  input wire logic [RES_BITS-1:0] analog_level, // Sampled analog level
  adc_link_if.dev link, // Bus side
  output logic busy // Conversion running
);
  import adc_pkg::*;

  // ==========================================================
  // Sizes, types and helpers
  localparam int DIV_W = $clog2(CLK_DIV + 1);

  typedef enum logic [1:0] {
    ADC_CV_IDLE,
    ADC_CV_RUN,
    ADC_CV_HELD
  } adc_cv_state_t;

  // Keeps the trial bit when the level reaches the trial code
  function automatic logic [RES_BITS-1:0] adc_trial(
    input logic [RES_BITS-1:0] level,
    input logic [RES_BITS-1:0] code,
    input logic [RES_BITS-1:0] mask
  );
    logic [RES_BITS-1:0] probe;
    probe = code | mask;
    if (level >= probe) begin
      return probe;
    end
    return code;
  endfunction

  // Top bit of the code, tried first in every conversion
  function automatic logic [RES_BITS-1:0] adc_first_bit();
    return {1'b1, {(RES_BITS-1){1'b0}}};
  endfunction

  // ==========================================================
  // State and datapath
  adc_cv_state_t state_reg;
  adc_cv_state_t state_next;
  logic start_armed_reg;
  logic start_pulse;
  logic [DIV_W-1:0] div_reg;
  logic div_wrap;
  logic step;
  logic last_step;
  logic running;
  logic finish;
  logic [RES_BITS-1:0] sar_reg;
  logic [RES_BITS-1:0] sar_next;
  logic [RES_BITS-1:0] trial_bit_reg;
  logic [RES_BITS-1:0] latch_reg;
  logic done_n_reg;
  logic busy_reg;

  // ==========================================================
  // Start detection
  // Start is the rising edge of write after select and write were low
  assign start_pulse = start_armed_reg && link.write_strobe_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      start_armed_reg <= 1'b0;
    end else if (clk_en) begin
      start_armed_reg <= !link.device_select_n && !link.write_strobe_n;
    end
  end

  // ==========================================================
  // Step timing from the selected conversion clock
  assign div_wrap = (div_reg == DIV_W'(CLK_DIV - 1));
  assign step = conv_clk_en && (div_reg == '0);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else if (clk_en) begin
      if (start_pulse) begin
        div_reg <= '0;
      end else if (conv_clk_en) begin
        if (div_wrap) begin
          div_reg <= '0;
        end else begin
          div_reg <= div_reg + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Conversion phase
  assign running = (state_reg == ADC_CV_RUN);
  assign last_step = running && step && trial_bit_reg[0];
  // A write still held low means a restart is under way: no completion
  assign finish = last_step && !start_armed_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ADC_CV_IDLE: begin
        if (start_pulse) begin
          state_next = ADC_CV_RUN;
        end
      end
      ADC_CV_RUN: begin
        if (start_pulse) begin
          state_next = ADC_CV_RUN;
        end else if (last_step) begin
          state_next = ADC_CV_HELD;
        end
      end
      ADC_CV_HELD: begin
        if (start_pulse) begin
          state_next = ADC_CV_RUN;
        end
      end
      default: begin
        state_next = ADC_CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ADC_CV_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= (state_next == ADC_CV_RUN);
    end
  end

  // ==========================================================
  // Successive approximation, one bit per step
  assign sar_next = adc_trial(analog_level, sar_reg, trial_bit_reg);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sar_reg <= '0;
    end else if (clk_en) begin
      if (start_pulse) begin
        sar_reg <= '0;
      end else if (running && step) begin
        sar_reg <= sar_next;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trial_bit_reg <= '0;
    end else if (clk_en) begin
      if (start_pulse) begin
        trial_bit_reg <= adc_first_bit();
      end else if (running && step) begin
        trial_bit_reg <= trial_bit_reg >> 1;
      end
    end
  end

  // ==========================================================
  // Output latch and done flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= RES_BITS'(`ADC_RESULT_RST);
    end else if (clk_en) begin
      if (finish) begin
        // Only a finished conversion reaches the latch
        latch_reg <= sar_next;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      done_n_reg <= 1'b1;
    end else if (clk_en) begin
      if (start_armed_reg) begin
        done_n_reg <= 1'b1;
      end else if (finish) begin
        done_n_reg <= 1'b0;
      end
    end
  end

  assign link.conversion_done_n = done_n_reg;
  assign link.result = latch_reg;
  assign busy = busy_reg;
endmodule

//--- hdl/adc_regs.svh
// Constants for the converter start and restart control
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
`define ADC_RES_BITS 8
`define ADC_CODE_STEPS 256
`define ADC_RESULT_RST 8'h00
`define ADC_CLK_DIV 4
`define ADC_SAMPLES 16
`define ADC_INIT_PULSE 2
`endif

//--- hdl/adc_pkg.sv
// Types shared by both ends of the converter control link
package adc_pkg;
  typedef logic [7:0] adc_code_t;
  typedef enum logic [1:0] {
    ADC_MODE_IDLE,
    ADC_MODE_BURST,
    ADC_MODE_FREE
  } adc_mode_t;
endpackage

//--- hdl/adc_link_if.sv
// Link between the converter control and the bus-side host
`timescale 1ns/1ps
interface adc_link_if;
  logic device_select_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic conversion_done_n;
  logic [7:0] result;
  modport dev (
    input device_select_n, write_strobe_n, read_strobe_n,
    output conversion_done_n, result
  );
  modport host (
    output device_select_n, write_strobe_n, read_strobe_n,
    input conversion_done_n, result
  );
endinterface

//--- hdl/adc_host.sv
// Host end: starts conversions and collects results
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_host #(
  parameter int SAMPLES = `ADC_SAMPLES,
  parameter int WAIT_CYCLES = 2
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire adc_pkg::adc_mode_t mode, // Idle, burst or free running
  input wire logic go, // Begin a burst
  adc_link_if.host link, // Converter side
  output logic [7:0] sample, // Last stored result
  output logic sample_valid, // Pulse per stored result
  output logic [$clog2(SAMPLES)-1:0] sample_index, // Store slot
  output logic burst_done // Burst of results finished
);
  import adc_pkg::*;

  typedef enum logic [2:0] {
    ADC_H_IDLE, ADC_H_WRITE, ADC_H_WAIT, ADC_H_READ, ADC_H_FREE
  } adc_hstate_t;

  // ==========================================================
  // Sequencer
  adc_hstate_t state_reg;
  logic [7:0] wait_reg;
  logic [$clog2(SAMPLES+1)-1:0] count_reg;
  logic sel_n_reg, wr_n_reg, rd_n_reg;
  logic [7:0] mem [SAMPLES];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ADC_H_IDLE;
      wait_reg <= '0;
      count_reg <= '0;
      sel_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      sample <= 8'h00;
      sample_valid <= 1'b0;
      sample_index <= '0;
      burst_done <= 1'b0;
    end else if (clk_en) begin
      sample_valid <= 1'b0;
      unique case (state_reg)
        ADC_H_IDLE: begin
          sel_n_reg <= 1'b1;
          wr_n_reg <= 1'b1;
          rd_n_reg <= 1'b1;
          if (mode == ADC_MODE_FREE) begin
            sel_n_reg <= 1'b0;
            wr_n_reg <= 1'b0;
            wait_reg <= 8'(`ADC_INIT_PULSE);
            state_reg <= ADC_H_FREE;
          end else if (mode == ADC_MODE_BURST && go) begin
            count_reg <= '0;
            burst_done <= 1'b0;
            sel_n_reg <= 1'b0;
            wr_n_reg <= 1'b0;
            wait_reg <= 8'(WAIT_CYCLES);
            state_reg <= ADC_H_WRITE;
          end
        end
        ADC_H_WRITE: begin
          if (wait_reg == 8'h00) begin
            sel_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            state_reg <= ADC_H_WAIT;
          end else begin
            wait_reg <= wait_reg - 8'h01;
          end
        end
        ADC_H_WAIT: begin
          if (!link.conversion_done_n) begin
            sel_n_reg <= 1'b0;
            rd_n_reg <= 1'b0;
            wait_reg <= 8'(WAIT_CYCLES);
            state_reg <= ADC_H_READ;
          end
        end
        ADC_H_READ: begin
          if (wait_reg == 8'h00) begin
            mem[count_reg[$clog2(SAMPLES)-1:0]] <= link.result;
            sample <= link.result;
            sample_valid <= 1'b1;
            sample_index <= count_reg[$clog2(SAMPLES)-1:0];
            rd_n_reg <= 1'b1;
            if (count_reg == ($clog2(SAMPLES+1))'(SAMPLES - 1)) begin
              sel_n_reg <= 1'b1;
              burst_done <= 1'b1;
              state_reg <= ADC_H_IDLE;
            end else begin
              count_reg <= count_reg + 1'b1;
              wr_n_reg <= 1'b0; // Next start
              wait_reg <= 8'(WAIT_CYCLES);
              state_reg <= ADC_H_WRITE;
            end
          end else begin
            wait_reg <= wait_reg - 8'h01;
          end
        end
        ADC_H_FREE: begin
          // Write follows done after the initialising pulse
          if (wait_reg != 8'h00) begin
            wait_reg <= wait_reg - 8'h01;
          end else begin
            wr_n_reg <= link.conversion_done_n;
          end
          if (wait_reg == 8'h00 && link.conversion_done_n == 1'b0 &&
              wr_n_reg) begin
            sample <= link.result;
            sample_valid <= 1'b1;
          end
          if (mode != ADC_MODE_FREE) begin
            state_reg <= ADC_H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.device_select_n = sel_n_reg;
  assign link.write_strobe_n = wr_n_reg;
  assign link.read_strobe_n = rd_n_reg;
endmodule

//--- sim/adc_link_asserts.sv
// Assertions on the link between the converter and host ends
`timescale 1ns/1ps
module adc_link_asserts (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic device_select_n, // Select from host
  input wire logic write_strobe_n, // Write strobe from host
  input wire logic read_strobe_n, // Read strobe from host
  input wire logic conversion_done_n, // Done from converter
  input wire logic [7:0] result // Result latch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Start detection and link properties
  sequence s_start;
    !$past(device_select_n) && !$past(write_strobe_n) && write_strobe_n;
  endsequence
  property p_done_hold;
    !conversion_done_n && write_strobe_n |=> !conversion_done_n;
  endproperty
  property p_result_stable;
    $changed(result) |-> $fell(conversion_done_n);
  endproperty
  property p_fresh_run;
    s_start |-> conversion_done_n [*8];
  endproperty
  property p_done_in_time;
    s_start |-> ##[1:200] !conversion_done_n;
  endproperty
  property p_abort_high;
    !write_strobe_n && !device_select_n |-> ##2 conversion_done_n;
  endproperty
  property p_reset_state;
    $rose(resetn) |-> conversion_done_n && result == 8'h00;
  endproperty
  property p_write_selected;
    !write_strobe_n |-> !device_select_n;
  endproperty
  property p_min_length;
    $fell(conversion_done_n) |-> $past(conversion_done_n, 8);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done released without a new start");
  a_result_stable: assert property (p_result_stable)
    else $error("result changed outside a completion");
  a_fresh_run: assert property (p_fresh_run)
    else $error("done fell too soon after a start");
  a_done_in_time: assert property (p_done_in_time)
    else $error("conversion never completed");
  a_abort_high: assert property (p_abort_high)
    else $error("done low after a start request");
  a_reset_state: assert property (p_reset_state)
    else $error("wrong link state after reset");
  a_write_selected: assert property (p_write_selected)
    else $error("write strobe without select");
  a_min_length: assert property (p_min_length)
    else $error("conversion shorter than its steps");
  c_start: cover property (s_start);
  c_done: cover property ($fell(conversion_done_n));
  c_read: cover property ($fell(read_strobe_n));
endmodule

//--- sim/tb_adc_start_restart_control.sv
// Testbench for the converter start and restart control
`timescale 1ns/1ps
`include "adc_regs.svh"
module tb_adc_start_restart_control;
  import adc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic en = 1'b1;
  logic conv_en_b = 1'b1;
  logic go = 1'b0;
  adc_mode_t mode = ADC_MODE_IDLE;
  logic [7:0] lvl_a = 8'h96;
  logic [7:0] lvl_b = 8'h00;
  logic [7:0] sample;
  logic sample_valid;
  logic [3:0] sample_index;
  logic burst_done;
  logic busy_b;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  adc_link_if link_a ();
  adc_link_if link_b ();
  adc_ctrl i_adc_ctrl (.sys_clk(sys_clk), .resetn(resetn), .clk_en(en),
    .conv_clk_en(1'b1), .analog_level(lvl_a), .link(link_a), .busy());
  adc_ctrl i_adc_ctrl_b (.sys_clk(sys_clk), .resetn(resetn), .clk_en(en),
    .conv_clk_en(conv_en_b), .analog_level(lvl_b), .link(link_b),
    .busy(busy_b));
  adc_host i_adc_host (.sys_clk(sys_clk), .resetn(resetn), .clk_en(en),
    .mode(mode), .go(go), .link(link_a), .sample(sample),
    .sample_valid(sample_valid), .sample_index(sample_index),
    .burst_done(burst_done));
  adc_link_asserts i_adc_link_asserts (.sys_clk(sys_clk), .resetn(resetn),
    .device_select_n(link_a.device_select_n),
    .write_strobe_n(link_a.write_strobe_n),
    .read_strobe_n(link_a.read_strobe_n),
    .conversion_done_n(link_a.conversion_done_n), .result(link_a.result));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic start_b();
    tick(1);
    link_b.device_select_n = 1'b0;
    link_b.write_strobe_n = 1'b0;
    tick(1);
    link_b.device_select_n = 1'b1;
    link_b.write_strobe_n = 1'b1;
  endtask
  task automatic wait_done_b(output int n);
    n = 0;
    while (link_b.conversion_done_n !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_codes();
    logic [7:0] codes [3];
    int n;
    codes = '{8'h00, 8'hFF, 8'hA5};
    foreach (codes[i]) begin
      lvl_b = codes[i];
      start_b();
      tick(1);
      chk(link_b.conversion_done_n, 1'b1);
      wait_done_b(n);
      chk(8'(n), 8'((`ADC_RES_BITS - 1) * `ADC_CLK_DIV + 1));
      chk(link_b.conversion_done_n, 1'b0);
      chk(link_b.result, codes[i]);
    end
  endtask
  task automatic t_restart();
    int n;
    lvl_b = 8'h3C;
    start_b();
    tick(12);
    lvl_b = 8'hC3;
    start_b();
    conv_en_b = 1'b0;
    tick(6);
    chk(link_b.conversion_done_n, 1'b1);
    chk(link_b.result, 8'hA5);
    chk(busy_b, 1'b1);
    conv_en_b = 1'b1;
    wait_done_b(n);
    chk(link_b.result, 8'hC3);
    chk(busy_b, 1'b0);
  endtask
  task automatic t_burst();
    int got;
    int n;
    got = 0;
    n = 0;
    mode = ADC_MODE_BURST;
    go = 1'b1;
    tick(2);
    go = 1'b0;
    while (burst_done !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
      if (sample_valid === 1'b1) begin
        chk(sample, lvl_a);
        chk(8'(sample_index), 8'(got));
        got++;
      end
    end
    chk(8'(got), 8'd16);
  endtask
  task automatic t_free();
    int falls;
    logic prev;
    falls = 0;
    mode = ADC_MODE_FREE;
    prev = link_a.conversion_done_n;
    repeat (400) begin
      tick(1);
      if (prev === 1'b1 && link_a.conversion_done_n === 1'b0) falls++;
      if (sample_valid === 1'b1) chk(sample, lvl_a);
      prev = link_a.conversion_done_n;
    end
    chk(8'(falls > 2), 8'd1);
  endtask
  initial begin
    link_b.device_select_n = 1'b1;
    link_b.write_strobe_n = 1'b1;
    link_b.read_strobe_n = 1'b1;
    tick(12);
    resetn = 1'b1;
    chk(link_b.conversion_done_n, 1'b1);
    t_codes();
    t_restart();
    t_burst();
    t_free();
    give_verdict();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("ERROR %0t: run timed out", $time);
      give_verdict();
    end
  end
endmodule
